/* File: hw/bpwm_pkg.sv */
// Constants shared by the three-channel motor PWM block and its bench.
// Assumes one 100 MHz system clock that also serves as the PWM count clock.
package bpwm_pkg;

	// Value widths
	localparam int BPWM_VW = 10;                  // Duty, period and counter width
	localparam int BPWM_NV = 4;                   // Stored values: duty 0..2, period

	// Register byte addresses, one 32-bit word each
	localparam logic [7:0] BPWM_OFS_DUTY0_LO = 8'h00;
	localparam logic [7:0] BPWM_OFS_DUTY0_HI = 8'h04;
	localparam logic [7:0] BPWM_OFS_DUTY1_LO = 8'h08;
	localparam logic [7:0] BPWM_OFS_DUTY1_HI = 8'h0c;
	localparam logic [7:0] BPWM_OFS_DUTY2_LO = 8'h10;
	localparam logic [7:0] BPWM_OFS_DUTY2_HI = 8'h14;
	localparam logic [7:0] BPWM_OFS_PRD_LO   = 8'h18;
	localparam logic [7:0] BPWM_OFS_PRD_HI   = 8'h1c;
	localparam logic [7:0] BPWM_OFS_CNT_LO   = 8'h20;
	localparam logic [7:0] BPWM_OFS_CNT_HI   = 8'h24;
	localparam logic [7:0] BPWM_OFS_MCFG     = 8'h28;
	localparam logic [7:0] BPWM_OFS_STAT     = 8'h2c;
	localparam logic [7:0] BPWM_OFS_CTRL     = 8'h30;

	// Motor output config fields
	localparam int BPWM_MCFG_MASK_MODE = 7;       // 0 hardware, 1 software mask
	localparam int BPWM_MCFG_NONCOMP   = 3;       // 0 complementary, 1 non-complementary
	localparam int BPWM_MCFG_PWM_EN    = 2;       // PWM output enable
	localparam int BPWM_MCFG_PROT_SEL  = 1;       // Protection output select
	localparam int BPWM_MCFG_SIDE      = 0;       // 0 low sides, 1 high sides
	localparam logic [7:0] BPWM_MCFG_RST = 8'h04; // Reset value
	localparam logic [7:0] BPWM_MCFG_WMASK = 8'h8f; // Implemented bits

	// Control fields
	localparam int BPWM_CTRL_RELOAD  = 0;         // Reload at overflow or underflow
	localparam int BPWM_CTRL_CENTER  = 1;         // 0 edge, 1 center aligned
	localparam int BPWM_CTRL_BRAKE   = 2;         // Brake mode
	localparam int BPWM_CTRL_PROTECT = 3;         // Motor protection mode
	localparam logic [7:0] BPWM_CTRL_RST   = 8'h00;
	localparam logic [7:0] BPWM_CTRL_WMASK = 8'h0f;

	// Status fields
	localparam int BPWM_STAT_GATE_LSB = 3;        // Gate levels bits 5..3
	localparam int BPWM_STAT_HALL_LSB = 0;        // Filtered hall bits 2..0

	// Counting direction of the PWM counter
	typedef enum logic [0:0] {
		BPWM_UP   = 1'b0,
		BPWM_DOWN = 1'b1
	} bpwm_dir_t;

endpackage

/* File: hw/bpwm_core.sv */
// Three-channel 10-bit PWM generator with the motor mask output stage.
// Assumes an Avalon-MM master on clk, commutation inputs on clk, and
// filtered hall levels and a fault level that arrive from outside clk.

module bpwm_core (
	input  wire logic        clk,                 // System clock, 100 MHz
	input  wire logic        rst,                 // Asynchronous reset, active high
	input  wire logic [7:0]  avs_address,         // Byte address
	input  wire logic        avs_read,            // Read request
	input  wire logic        avs_write,           // Write request
	input  wire logic [31:0] avs_writedata,       // Write data
	input  wire logic [3:0]  avs_byteenable,      // Byte lanes
	output logic      [31:0] avs_readdata,        // Read data
	output logic             avs_waitrequest,     // Stall the master
	input  wire logic [2:0]  comm_top,            // Commutation top per phase
	input  wire logic [2:0]  comm_bot,            // Commutation bottom per phase
	input  wire logic [2:0]  filtered_hall,       // Filtered hall levels, async
	input  wire logic        fault_in,            // Protection trigger, async
	output logic [2:0]       top_gate,            // High side gates a, b, c
	output logic [2:0]       bottom_gate          // Low side gates a, b, c
);

	// Decode one phase in hardware mask mode, returns {top, bottom}
	function automatic logic [1:0] hw_decode(input logic t, input logic b,
		input logic p, input logic side, input logic noncomp);
		logic [1:0] r;
		r = 2'b00;
		if (!t && b) begin
			if (side) r = 2'b01;
			else r = noncomp ? {1'b0, p} : {~p, p};
		end else if (t && !b) begin
			if (!side) r = 2'b10;
			else r = noncomp ? {p, 1'b0} : {p, ~p};
		end
		return r;
	endfunction

	// Bus handshake state
	logic        ack_r;                             // Second cycle of an access
	logic [31:0] rdata_r;                           // Registered read data
	wire         req     = avs_read | avs_write;    // Any request
	wire         wr_acc  = avs_write & ack_r;       // Write takes effect
	wire         wr_lane = wr_acc & avs_byteenable[0]; // Data sits in lane 0

	// Stored values, high-byte buffers and active copies
	logic [bpwm_pkg::BPWM_VW-1:0] val_r  [bpwm_pkg::BPWM_NV];
	logic [1:0]                   hbuf_r [bpwm_pkg::BPWM_NV];
	logic [bpwm_pkg::BPWM_VW-1:0] act_r  [bpwm_pkg::BPWM_NV];

	// Config, control and counter
	logic [7:0]                   mcfg_r;           // Motor output config
	logic [7:0]                   ctrl_r;           // Control bits
	logic [bpwm_pkg::BPWM_VW-1:0] cnt_r;            // Live counter
	logic [bpwm_pkg::BPWM_VW-1:0] cnt_nxt;          // Next counter
	bpwm_pkg::bpwm_dir_t          dir_r;            // Count direction
	bpwm_pkg::bpwm_dir_t          dir_nxt;          // Next direction

	// Synchronisers for outside levels
	logic [2:0] hall_s1_r, hall_s2_r;               // Hall levels, no reset
	logic       fault_s1_r, fault_s2_r;             // Fault level

	// Registered commutation pairs and gates
	logic [2:0] ctop_r, cbot_r;                     // Registered commutation
	logic [2:0] top_r, bot_r;                       // Registered gates
	logic [2:0] top_nxt, bot_nxt;                   // Next gates

	// Address hits per stored value
	logic [bpwm_pkg::BPWM_NV-1:0] lo_hit, hi_hit;
	assign lo_hit[0] = avs_address == bpwm_pkg::BPWM_OFS_DUTY0_LO;
	assign lo_hit[1] = avs_address == bpwm_pkg::BPWM_OFS_DUTY1_LO;
	assign lo_hit[2] = avs_address == bpwm_pkg::BPWM_OFS_DUTY2_LO;
	assign lo_hit[3] = avs_address == bpwm_pkg::BPWM_OFS_PRD_LO;
	assign hi_hit[0] = avs_address == bpwm_pkg::BPWM_OFS_DUTY0_HI;
	assign hi_hit[1] = avs_address == bpwm_pkg::BPWM_OFS_DUTY1_HI;
	assign hi_hit[2] = avs_address == bpwm_pkg::BPWM_OFS_DUTY2_HI;
	assign hi_hit[3] = avs_address == bpwm_pkg::BPWM_OFS_PRD_HI;
	wire mcfg_hit = avs_address == bpwm_pkg::BPWM_OFS_MCFG;
	wire ctrl_hit = avs_address == bpwm_pkg::BPWM_OFS_CTRL;

	// Named control fields
	wire center   = ctrl_r[bpwm_pkg::BPWM_CTRL_CENTER];
	wire reload   = ctrl_r[bpwm_pkg::BPWM_CTRL_RELOAD];
	wire brake    = ctrl_r[bpwm_pkg::BPWM_CTRL_BRAKE];
	wire protect  = ctrl_r[bpwm_pkg::BPWM_CTRL_PROTECT] | fault_s2_r;
	wire sw_mask  = mcfg_r[bpwm_pkg::BPWM_MCFG_MASK_MODE];
	wire noncomp  = mcfg_r[bpwm_pkg::BPWM_MCFG_NONCOMP];
	wire pwm_en   = mcfg_r[bpwm_pkg::BPWM_MCFG_PWM_EN];
	wire prot_sel = mcfg_r[bpwm_pkg::BPWM_MCFG_PROT_SEL];
	wire side     = mcfg_r[bpwm_pkg::BPWM_MCFG_SIDE];
	wire [bpwm_pkg::BPWM_VW-1:0] prd = act_r[3];

	// Status byte: gates a top, a bottom, b top, then filtered halls
	wire [7:0] stat = {2'b00, top_r[0], bot_r[0], top_r[1], hall_s2_r};

	// Read multiplexer; write-only and unmapped words read zero
	wire [31:0] rd_mux =
		(avs_address == bpwm_pkg::BPWM_OFS_CNT_LO) ? {24'h000000, cnt_r[7:0]} :
		(avs_address == bpwm_pkg::BPWM_OFS_CNT_HI) ? {22'h0, cnt_r[9:8]} :
		mcfg_hit ? {24'h000000, mcfg_r} :
		(avs_address == bpwm_pkg::BPWM_OFS_STAT) ? {24'h000000, stat} :
		ctrl_hit ? {24'h000000, ctrl_r} : 32'h00000000;

	// Every access waits exactly one cycle
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata    = rdata_r;

	// Handshake and read capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= req & ~ack_r;
			if (avs_read && !ack_r) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// Config and control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mcfg_r <= bpwm_pkg::BPWM_MCFG_RST;
			ctrl_r <= bpwm_pkg::BPWM_CTRL_RST;
		end else begin
			if (wr_lane && mcfg_hit) begin
				mcfg_r <= avs_writedata[7:0] & bpwm_pkg::BPWM_MCFG_WMASK;
			end
			if (wr_lane && ctrl_hit) begin
				ctrl_r <= avs_writedata[7:0] & bpwm_pkg::BPWM_CTRL_WMASK;
			end
		end
	end

	// Counter boundary events
	wire ovf    = cnt_r >= prd;                                   // Top or wrap
	wire udf    = center && (dir_r == bpwm_pkg::BPWM_DOWN) && (cnt_r <= 10'h001);
	wire reload_evt = reload & (ovf | udf);

	// Duty and period stores with high-byte buffers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < bpwm_pkg::BPWM_NV; i++) begin
				val_r[i]  <= '0;
				hbuf_r[i] <= 2'b00;
				act_r[i]  <= '0;
			end
		end else begin
			for (int i = 0; i < bpwm_pkg::BPWM_NV; i++) begin
				if (wr_lane && hi_hit[i]) begin
					hbuf_r[i] <= avs_writedata[1:0];
				end
				if (wr_lane && lo_hit[i]) begin
					val_r[i] <= {hbuf_r[i], avs_writedata[7:0]};
				end
				if (reload_evt) begin
					act_r[i] <= val_r[i];
				end
			end
		end
	end

	// Next counter value for both alignments
	always_comb begin
		cnt_nxt = cnt_r + 10'h001;
		dir_nxt = dir_r;
		if (!center) begin
			dir_nxt = bpwm_pkg::BPWM_UP;
			if (ovf) cnt_nxt = '0;
		end else begin
			unique case (dir_r)
				bpwm_pkg::BPWM_UP: begin
					if (ovf) begin
						if (prd <= 10'h001) begin
							cnt_nxt = '0;
						end else begin
							cnt_nxt = prd - 10'h001;
							dir_nxt = bpwm_pkg::BPWM_DOWN;
						end
					end
				end
				bpwm_pkg::BPWM_DOWN: begin
					if (udf) begin
						cnt_nxt = '0;
						dir_nxt = bpwm_pkg::BPWM_UP;
					end else begin
						cnt_nxt = cnt_r - 10'h001;
					end
				end
			endcase
		end
	end

	// Counter and direction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			dir_r <= bpwm_pkg::BPWM_UP;
		end else begin
			cnt_r <= cnt_nxt;
			dir_r <= dir_nxt;
		end
	end

	// Outside levels pass two flip-flops
	always_ff @(posedge clk) begin
		hall_s1_r <= filtered_hall;
		hall_s2_r <= hall_s1_r;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_s1_r <= 1'b0;
			fault_s2_r <= 1'b0;
		end else begin
			fault_s1_r <= fault_in;
			fault_s2_r <= fault_s1_r;
		end
	end

	// Commutation pairs are registered before decoding
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctop_r <= 3'b000;
			cbot_r <= 3'b000;
		end else begin
			ctop_r <= comm_top;
			cbot_r <= comm_bot;
		end
	end

	// Per-phase wave and mask stage
	for (genvar g = 0; g < 3; g++) begin : g_phase
		wire       wave = cnt_r < act_r[g];
		wire       p    = pwm_en ? wave : 1'b1;
		wire [1:0] hw   = hw_decode(ctop_r[g], cbot_r[g], p, side, noncomp);
		wire [1:0] nrm  = sw_mask ? {p, ~p} : hw;
		assign top_nxt[g] = brake ? 1'b0 :
			protect ? 1'b0 : nrm[1];
		assign bot_nxt[g] = brake ? 1'b1 :
			protect ? prot_sel : nrm[0];
	end

	// Gate outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_r <= 3'b000;
			bot_r <= 3'b000;
		end else begin
			top_r <= top_nxt;
			bot_r <= bot_nxt;
		end
	end
	assign top_gate    = top_r;
	assign bottom_gate = bot_r;

	// Checks on the design's own behaviour, all on the system clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Sampled view of the counter low byte for the read check
	wire [7:0] cnt_lo = cnt_r[7:0];                 // Counter low byte

	// Brake forces every high side off and every low side on
	a_brake_gates: assert property (
		brake |=> top_gate == 3'b000 && bottom_gate == 3'b111)
		else $error("brake did not force low sides on");

	// Protection without brake follows the protect output select
	a_protect_state: assert property (
		!brake && protect |=> top_gate == 3'b000 && bottom_gate == {3{$past(prot_sel)}})
		else $error("protection output state wrong");

	// Edge mode wraps to zero after the period value
	a_edge_wrap: assert property (
		!center && !$past(center) && cnt_r == prd && prd != 10'h000 |=> cnt_r == 10'h000)
		else $error("edge counter did not wrap at period");

	// Edge mode counts up by one below the period value
	a_edge_step: assert property (
		!center && cnt_r < prd |=> cnt_r == $past(cnt_r) + 10'h001)
		else $error("edge counter did not step up");

	// Center mode turns down one below the top
	a_center_turn: assert property (
		center && dir_r == bpwm_pkg::BPWM_UP && cnt_r == prd && prd > 10'h001
		|=> dir_r == bpwm_pkg::BPWM_DOWN && cnt_r == $past(prd) - 10'h001)
		else $error("center counter did not turn at top");

	// Center mode counts down by one above the floor
	a_center_down: assert property (
		center && dir_r == bpwm_pkg::BPWM_DOWN && cnt_r > 10'h001
		|=> cnt_r == $past(cnt_r) - 10'h001)
		else $error("center counter did not step down");

	// Active values hold while reload is off
	a_reload_hold: assert property (
		!reload |=> act_r[3] == $past(act_r[3]) && act_r[0] == $past(act_r[0]))
		else $error("active values changed with reload off");

	// With reload on, a wrap copies the stored values
	a_reload_take: assert property (
		reload && ovf |=> act_r[3] == $past(val_r[3]) && act_r[0] == $past(val_r[0]))
		else $error("active values not reloaded at wrap");

	// A low byte write merges the buffered high bits
	a_low_merge: assert property (
		wr_lane && lo_hit[3] |=> val_r[3] == {$past(hbuf_r[3]), $past(avs_writedata[7:0])})
		else $error("low byte write did not merge buffer");

	// A high byte write only fills the buffer
	a_high_buffer: assert property (
		wr_lane && hi_hit[0]
		|=> hbuf_r[0] == $past(avs_writedata[1:0]) && val_r[0] == $past(val_r[0]))
		else $error("high byte write changed the value");

	// Write-only values read back as zero
	a_wo_read_zero: assert property (
		avs_read && !ack_r && ((|lo_hit) || (|hi_hit)) |=> avs_readdata == 32'h00000000)
		else $error("write-only value did not read zero");

	// Counter low byte read returns the live count
	a_cnt_low_read: assert property (
		avs_read && !ack_r && avs_address == bpwm_pkg::BPWM_OFS_CNT_LO
		|=> avs_readdata[7:0] == $past(cnt_lo))
		else $error("counter low byte read wrong");

	// Counter high byte keeps its upper bits at zero
	a_cnt_high_zero: assert property (
		avs_read && !ack_r && avs_address == bpwm_pkg::BPWM_OFS_CNT_HI
		|=> avs_readdata[31:2] == 30'h00000000)
		else $error("counter high byte upper bits not zero");

	// Low-side complementary decode of a 10 pair
	a_hw_low_side: assert property (
		!brake && !protect && !sw_mask && !side && !noncomp && ctop_r[0] && !cbot_r[0]
		|=> top_gate[0] && !bottom_gate[0])
		else $error("low side pwm decode wrong for 10");

	// High-side decode of a 01 pair turns the bottom on
	a_hw_high_side: assert property (
		!brake && !protect && !sw_mask && side && !noncomp && !ctop_r[0] && cbot_r[0]
		|=> !top_gate[0] && bottom_gate[0])
		else $error("high side decode wrong for 01");

	// Equal pair bits leave both gates off
	a_pair_idle: assert property (
		!brake && !protect && !sw_mask && ctop_r[1] == cbot_r[1]
		|=> !top_gate[1] && !bottom_gate[1])
		else $error("idle pair drove a gate");

	// Disabled modulation in software mask drives the tops steadily
	a_no_modulation: assert property (
		!brake && !protect && sw_mask && !pwm_en
		|=> top_gate == 3'b111 && bottom_gate == 3'b000)
		else $error("disabled pwm still modulated");

	// No leg ever has both switches on
	a_no_overlap: assert property (
		(top_gate & bottom_gate) == 3'b000)
		else $error("both gates of a leg on");

	// Every access waits exactly one cycle
	a_wait_one: assert property (
		req && !ack_r |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("access not answered after one wait cycle");

endmodule

/* File: test/bpwm_bridge_model.sv */
// Behavioural gate driver and half-bridge hanging on the six gate outputs.
// Assumes N-type switches, so a 1 on a gate turns its transistor on.
module bpwm_bridge_model (
	input  wire logic       clk,         // System clock
	input  wire logic [2:0] top_gate,    // High side gates a, b, c
	input  wire logic [2:0] bottom_gate, // Low side gates a, b, c
	output logic      [2:0] phase_out,   // Node level, high while only the top conducts
	output logic            shoot_seen   // Sticky, a leg had both switches on
);
	timeunit 1ns;
	timeprecision 1ns;
	// Node follows the conducting side, the load pulls a floating node low
	assign phase_out = top_gate & ~bottom_gate;
	// A real bridge would short here, so remember it for the bench
	initial begin
		shoot_seen = 1'b0;
		forever begin
			@(posedge clk);
			if ((top_gate & bottom_gate) != 3'h0) begin
				shoot_seen <= 1'b1;
			end
		end
	end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the three-channel motor PWM block.
// Assumes bpwm_pkg and bpwm_core are compiled first; one 100 MHz clock.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;             // System clock
	logic        rst;             // Reset, active high
	logic [7:0]  avs_address;     // Bus address
	logic        avs_read;        // Bus read
	logic        avs_write;       // Bus write
	logic [31:0] avs_writedata;   // Bus write data
	logic [3:0]  avs_byteenable;  // Bus lanes
	logic [31:0] avs_readdata;    // Bus read data
	logic        avs_waitrequest; // Bus stall
	logic [2:0]  comm_top;        // Commutation top bits
	logic [2:0]  comm_bot;        // Commutation bottom bits
	logic [2:0]  filtered_hall;   // Hall levels
	logic        fault_in;        // Protection trigger
	logic [2:0]  top_gate;        // High side gates
	logic [2:0]  bottom_gate;     // Low side gates
	logic [2:0]  phase_out;       // Bridge node levels
	logic        shoot_seen;      // Bridge short flag
	int          err_count;       // Mismatches
	int          num_checks;      // Comparisons
	logic [7:0]  rd;              // Last byte read
	int          hi;              // Counted high cycles
	logic [1:0]  e;               // Expected top and bottom of one phase
	bpwm_core i_bpwm_core (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .comm_top(comm_top), .comm_bot(comm_bot),
		.filtered_hall(filtered_hall), .fault_in(fault_in), .top_gate(top_gate),
		.bottom_gate(bottom_gate));
	bpwm_bridge_model i_bpwm_bridge_model (.clk(clk), .top_gate(top_gate),
		.bottom_gate(bottom_gate), .phase_out(phase_out), .shoot_seen(shoot_seen));
	// Clock source
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Single exit, prints counts then the verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Byte compare
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	// Gate pattern compare
	task automatic chk_gates(input logic [5:0] got, input logic [5:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t gates %b expected %b", $time, got, exp);
		end
	endtask
	// Cycle count compare
	task automatic chk_count(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			err_count++;
			$display("FAIL %0t high cycles %0d expected %0d", $time, got, exp);
		end
	endtask
	// One bus transfer, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
		if (n >= 50) begin
			err_count++;
			$display("FAIL %0t bus answer missing", $time);
			end_of_test();
		end
	endtask
	// Read one byte and compare it
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk_byte(rd, exp);
	endtask
	// Ten-bit value, high byte first so the buffer is loaded before the low byte
	task automatic setv(input logic [7:0] lo, input logic [9:0] v);
		bus(1'b1, lo + 8'h04, {6'h00, v[9:8]});
		bus(1'b1, lo, v[7:0]);
	endtask
	// Let the two-edge gate pipeline settle, then compare all six gates
	task automatic gates(input logic [5:0] exp);
		repeat (3) @(posedge clk);
		chk_gates({top_gate, bottom_gate}, exp);
	endtask
	// Count high cycles of phase a bottom gate over a whole number of periods
	task automatic count_high(input int n, input int exp);
		hi = 0;
		repeat (n) begin
			@(posedge clk);
			hi += (bottom_gate[0] === 1'b1) ? 1 : 0;
		end
		chk_count(hi, exp);
	endtask
	// Expected {top, bottom} of one phase in hardware mask operation
	function automatic logic [1:0] exp_pair(logic s, logic nc, logic [1:0] p, logic w);
		if (p == 2'b01) begin
			return s ? 2'b01 : {(nc ? 1'b0 : ~w), w};
		end
		if (p == 2'b10) begin
			return s ? {w, (nc ? 1'b0 : ~w)} : 2'b10;
		end
		return 2'b00;
	endfunction
	// Main sequence
	initial begin
		rst = 1'b1;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		avs_byteenable = 4'h1;
		{comm_top, comm_bot, fault_in} = '0;
		filtered_hall = 3'b101;
		err_count = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(bpwm_pkg::BPWM_OFS_MCFG, 8'h04);
		rdchk(bpwm_pkg::BPWM_OFS_CNT_LO, 8'h00);
		rdchk(bpwm_pkg::BPWM_OFS_CNT_HI, 8'h00);
		rdchk(bpwm_pkg::BPWM_OFS_STAT, 8'h05);
		rdchk(bpwm_pkg::BPWM_OFS_DUTY0_HI, 8'h00);
		rdchk(8'h3c, 8'h00);
		avs_byteenable <= 4'h0;
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h00);
		avs_byteenable <= 4'h1;
		rdchk(bpwm_pkg::BPWM_OFS_MCFG, 8'h04);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'hff);
		rdchk(bpwm_pkg::BPWM_OFS_MCFG, 8'h8f);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h04);
		setv(bpwm_pkg::BPWM_OFS_PRD_LO, 10'h105);
		setv(bpwm_pkg::BPWM_OFS_DUTY0_LO, 10'h102);
		repeat (5) @(posedge clk);
		rdchk(bpwm_pkg::BPWM_OFS_CNT_LO, 8'h00);
		comm_bot <= 3'b111;
		bus(1'b1, bpwm_pkg::BPWM_OFS_CTRL, 8'h01);
		repeat (300) @(posedge clk);
		bus(1'b0, bpwm_pkg::BPWM_OFS_CNT_HI, 8'h00);
		chk_byte(rd & 8'hfc, 8'h00);
		count_high(262, 258);
		bus(1'b1, bpwm_pkg::BPWM_OFS_CTRL, 8'h03);
		repeat (600) @(posedge clk);
		count_high(522, 515);
		bus(1'b1, bpwm_pkg::BPWM_OFS_CTRL, 8'h01);
		// Phases b and c: zero duty gives a low wave, disable gives a high one
		for (int en = 0; en < 2; en++) begin
			for (int k = 0; k < 16; k++) begin
				bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, {4'h0, k[3], en[0], 1'b0, k[2]});
				comm_top <= {3{k[1]}};
				comm_bot <= {3{k[0]}};
				e = exp_pair(k[2], k[3], k[1:0], ~en[0]);
				repeat (3) @(posedge clk);
				chk_gates({2'b00, top_gate[2:1], bottom_gate[2:1]}, {2'b00, e[1], e[1], e[0], e[0]});
			end
		end
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h80);
		gates(6'b111000);
		chk_byte({5'h00, phase_out}, 8'h07);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h88);
		gates(6'b111000);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h04);
		bus(1'b1, bpwm_pkg::BPWM_OFS_CTRL, 8'h09);
		gates(6'b000000);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h06);
		gates(6'b000111);
		rdchk(bpwm_pkg::BPWM_OFS_STAT, 8'h15);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h04);
		bus(1'b1, bpwm_pkg::BPWM_OFS_CTRL, 8'h0d);
		gates(6'b000111);
		bus(1'b1, bpwm_pkg::BPWM_OFS_MCFG, 8'h06);
		bus(1'b1, bpwm_pkg::BPWM_OFS_CTRL, 8'h01);
		gates(6'b000000);
		// Fault passes two sync stages before the gate register
		fault_in <= 1'b1;
		@(posedge clk);
		gates(6'b000111);
		fault_in <= 1'b0;
		chk_byte({7'h00, shoot_seen}, 8'h00);
		end_of_test();
	end
endmodule
